// ==== common/tx_cmd_cfg.svh ====
`ifndef TX_CMD_CFG_SVH
`define TX_CMD_CFG_SVH
// Command word A field positions
`define ALIGN_HI 25
`define ALIGN_LO 24
`define OFFSET_HI 20
`define OFFSET_LO 16
`define FIRST_BIT 13
`define LAST_BIT 12
`define SIZE_HI 10
`define SIZE_LO 0
// Command word B packet length field
`define PLEN_HI 10
`define PLEN_LO 0
// Alignment codes
`define ALIGN_4 2'h0
`define ALIGN_16 2'h1
`define ALIGN_32 2'h2
`define ALIGN_RSVD 2'h3
`endif

// ==== common/tx_cmd_pkg.sv ====
`default_nettype none
package tx_cmd_pkg;
    // Word position within one buffer
    typedef enum logic [1:0] {
        ST_CMD_A = 2'b00,
        ST_CMD_B = 2'b01,
        ST_DATA = 2'b10
    } state_e;
endpackage
`default_nettype wire

// ==== hdl/tx_command_a_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tx_cmd_cfg.svh"

module tx_command_a_decoder (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic in_valid,
    input wire logic [31:0] in_data,
    output logic out_valid,
    output logic [31:0] out_data,
    output logic [3:0] out_byte_en,
    output logic out_first,
    output logic out_last,
    output logic first_fragment_flag,
    output logic [1:0] end_align,
    output logic [4:0] start_offset,
    output logic [10:0] buf_size,
    output logic transmit_error_flag,
    input wire logic error_clear
);
    // Word counter state
    tx_cmd_pkg::state_e state_r;
    // Words left in buffer, payload and total
    logic [11:0] data_left_r;
    logic [11:0] words_left_r;
    // Offset DWORDs still to skip
    logic [2:0] skip_r;
    // Latched command A fields
    logic last_seg_r;
    logic first_pend_r;
    logic [1:0] lane_r;
    logic [1:0] tail_r;
    // Per-packet size accumulator, one bit wider than a length so overshoot mismatches
    logic [11:0] sum_r;
    logic [11:0] sum_nxt;
    // Command A fields seen on the input word
    logic [10:0] cmd_size;
    logic [4:0] cmd_off;
    logic [1:0] cmd_align;
    // Byte span rounded up for DWORD counting
    logic [11:0] span;
    // DWORDs touched by offset plus payload
    logic [11:0] payload_words;
    // DWORDs the host really sends after padding
    logic [11:0] total_words;
    // Lane mask for the word now being taken
    logic [3:0] be_nxt;
    // Word accepted this cycle
    logic take;

    assign take = clk_en && in_valid;
    assign cmd_size = in_data[`SIZE_HI:`SIZE_LO];
    assign cmd_off = in_data[`OFFSET_HI:`OFFSET_LO];
    assign cmd_align = in_data[`ALIGN_HI:`ALIGN_LO];

    // Payload span in DWORDs from start of data area
    always_comb begin
        span = 12'(cmd_size) + 12'(cmd_off) + 12'h003;
        payload_words = {2'h0, span[11:2]};
        // Round up to alignment; padding is total minus payload
        case (cmd_align)
            `ALIGN_4: total_words = payload_words;
            `ALIGN_16: total_words = (payload_words + 12'h003) & 12'hFFC;
            `ALIGN_32: total_words = (payload_words + 12'h007) & 12'hFF8;
            default: total_words = payload_words;
        endcase
    end

    // Sum restarts on a first segment, otherwise accumulates
    always_comb begin
        // Read on every word, used only on command A
        if (in_data[`FIRST_BIT]) begin
            sum_nxt = 12'(cmd_size);
        end else begin
            sum_nxt = sum_r + 12'(cmd_size);
        end
    end

    // Sequencer over command A, command B and data words
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= tx_cmd_pkg::ST_CMD_A;
            data_left_r <= 12'h000;
            words_left_r <= 12'h000;
            skip_r <= 3'h0;
        end else if (take) begin
            case (state_r)
                tx_cmd_pkg::ST_CMD_A: begin
                    state_r <= tx_cmd_pkg::ST_CMD_B;
                    skip_r <= cmd_off[4:2];
                    // Empty buffer carries no payload even with an unaligned offset
                    if (cmd_size == 11'h000) begin
                        data_left_r <= 12'h000;
                    end else begin
                        data_left_r <= payload_words - 12'(cmd_off[4:2]);
                    end
                    words_left_r <= total_words;
                end
                // Command B only carries the length, checked in the error process
                tx_cmd_pkg::ST_CMD_B: begin
                    // Zero size with zero offset gives no data words at all
                    state_r <= (words_left_r == 12'h000) ? tx_cmd_pkg::ST_CMD_A
                                                          : tx_cmd_pkg::ST_DATA;
                end
                // Offset words go first, then payload, then padding
                tx_cmd_pkg::ST_DATA: begin
                    words_left_r <= words_left_r - 12'h001;
                    if (skip_r != 3'h0) begin
                        skip_r <= skip_r - 3'h1;
                    end else if (data_left_r != 12'h000) begin
                        data_left_r <= data_left_r - 12'h001;
                    end
                    if (words_left_r == 12'h001) begin
                        state_r <= tx_cmd_pkg::ST_CMD_A;
                    end
                end
                default: state_r <= tx_cmd_pkg::ST_CMD_A;
            endcase
        end
    end

    // Decoded command A fields, held until the next command A
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            first_fragment_flag <= 1'b0;
            end_align <= 2'h0;
            start_offset <= 5'h00;
            buf_size <= 11'h000;
            last_seg_r <= 1'b0;
            first_pend_r <= 1'b0;
            lane_r <= 2'h0;
            tail_r <= 2'h0;
        end else if (take) begin
            if (state_r == tx_cmd_pkg::ST_CMD_A) begin
                first_fragment_flag <= in_data[`FIRST_BIT];
                end_align <= cmd_align;
                start_offset <= cmd_off;
                buf_size <= cmd_size;
                last_seg_r <= in_data[`LAST_BIT];
                // Lane mask waits for the first payload word
                first_pend_r <= 1'b1;
                lane_r <= cmd_off[1:0];
                // Byte count of the last payload word, 0 meaning full
                tail_r <= 2'(span[1:0] + 2'h1);
            end else if (state_r == tx_cmd_pkg::ST_DATA && skip_r == 3'h0) begin
                first_pend_r <= 1'b0;
            end
        end
    end

    // Packet length accumulation and check
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sum_r <= 12'h000;
            transmit_error_flag <= 1'b0;
        end else if (clk_en) begin
            if (take && state_r == tx_cmd_pkg::ST_CMD_A) begin
                sum_r <= sum_nxt;
                // Set wins over a clear arriving in the same cycle
                if (cmd_align == `ALIGN_RSVD) begin
                    transmit_error_flag <= 1'b1;
                end else if (error_clear) begin
                    transmit_error_flag <= 1'b0;
                end
            end else if (take && state_r == tx_cmd_pkg::ST_CMD_B && last_seg_r
                         && sum_r != 12'(in_data[`PLEN_HI:`PLEN_LO])) begin
                transmit_error_flag <= 1'b1;
            end else if (error_clear) begin
                transmit_error_flag <= 1'b0;
            end
        end
    end

    // First word drops lanes below the offset, closing word drops unused top lanes
    always_comb begin
        be_nxt = 4'hF;
        if (first_pend_r) begin
            be_nxt = 4'(4'hF << lane_r);
        end
        // A one-word buffer takes both masks at once
        if (data_left_r == 12'h001 && tail_r != 2'h0) begin
            be_nxt = be_nxt & 4'(4'hF >> (3'h4 - {1'b0, tail_r}));
        end
    end

    // Output stream: offset and padding words dropped, lanes marked
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            out_data <= 32'h00000000;
            out_byte_en <= 4'h0;
            out_first <= 1'b0;
            out_last <= 1'b0;
        end else if (clk_en) begin
            // Padding and skipped words never raise out_valid
            out_valid <= take && state_r == tx_cmd_pkg::ST_DATA
                         && skip_r == 3'h0 && data_left_r != 12'h000;
            // Data copied on every enabled cycle; only out_valid qualifies it
            out_data <= in_data;
            out_first <= first_pend_r && first_fragment_flag;
            out_last <= data_left_r == 12'h001 && last_seg_r;
            out_byte_en <= be_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== dv/tx_command_a_decoder_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches only the decoder's own ports
module tx_command_a_decoder_sva (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic in_valid,
    input wire logic error_clear,
    input wire logic out_valid,
    input wire logic out_first,
    input wire logic out_last,
    input wire logic transmit_error_flag,
    input wire logic [31:0] in_data,
    input wire logic [31:0] out_data,
    input wire logic [3:0] out_byte_en,
    input wire logic [1:0] end_align,
    input wire logic [4:0] start_offset,
    input wire logic [10:0] buf_size
);
    logic [1:0] tail; // Bytes in closing word, 0 means full
    assign tail = 2'(buf_size[1:0] + start_offset[1:0]);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_out_cause: assert property (out_valid |-> $past(in_valid && clk_en))
        else $error("word without input");
    a_data_copy: assert property (out_valid |-> out_data == $past(in_data))
        else $error("word altered");
    a_fields_hold: assert property (!(in_valid && clk_en) |=>
        $stable({end_align, start_offset, buf_size})) else $error("fields moved");
    a_err_hold: assert property (transmit_error_flag && !error_clear |=>
        transmit_error_flag) else $error("error dropped");
    a_err_cause: assert property ($rose(transmit_error_flag) |->
        $past(in_valid && clk_en)) else $error("error without word");
    a_first_lane: assert property (out_valid && out_first && !out_last |->
        out_byte_en == 4'(4'hF << start_offset[1:0])) else $error("first lanes");
    a_last_lane: assert property (out_valid && out_last && !out_first |->
        out_byte_en == (tail == 2'h0 ? 4'hF : 4'(4'h1 << tail) - 4'h1)) else $error("last lanes");
    a_rsvd_err: assert property ($changed(end_align) && end_align == 2'h3 |->
        ##[0:1] transmit_error_flag) else $error("reserved not flagged");
endmodule
bind tx_command_a_decoder tx_command_a_decoder_sva chk_i (.*);
`default_nettype wire

// ==== dv/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic ref_clk,
    output logic in_valid,
    output logic [31:0] in_data
);
    initial begin
        in_valid = 1'b0;
        in_data = 32'h0;
    end
    task automatic put(input logic [31:0] w);
        @(negedge ref_clk);
        in_valid = 1'b1;
        in_data = w;
    endtask
    // Cmd A, cmd B, data padded to the end alignment, then idle
    task automatic send_buf(input logic [1:0] al, input logic [4:0] of, input logic fs, ls,
        input logic [10:0] sz, pl);
        int u = al == 2'h1 ? 4 : al == 2'h2 ? 8 : 1;
        int n = (sz + of + 4 * u - 1) / (4 * u) * u;
        put({6'h0, al, 3'h0, of, 2'h0, fs, ls, 1'b0, sz});
        put({21'h0, pl});
        for (int i = 0; i < n; i++) put(32'hD0000000 + i);
        @(negedge ref_clk);
        in_valid = 1'b0;
        in_data = ~in_data; // Idle bus never repeats the last word
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_tx_command_a_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_tx_command_a_decoder;
    logic ref_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, error_clear = 1'b0, in_valid;
    logic out_valid, out_first, out_last, first_fragment_flag, transmit_error_flag;
    logic [31:0] in_data, out_data;
    logic [3:0] out_byte_en;
    logic [1:0] end_align;
    logic [4:0] start_offset;
    logic [10:0] buf_size;
    int n_mismatch = 0, tests_run = 0, n_out = 0;
    int n_bytes = 0, n_first = 0, n_last = 0;
    tx_command_a_decoder uut (.*);
    host_model host (.*);
    initial forever #2.5 ref_clk = ~ref_clk;
    // Tally what the stream hands on, so each buffer is judged afterwards
    always @(posedge ref_clk) begin
        if (out_valid === 1'b1) begin
            n_out += 1;
            n_bytes += $countones(out_byte_en);
            n_first += int'(out_first === 1'b1);
            n_last += int'(out_last === 1'b1);
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic results;
        $display("%0d checks, %0d mismatches", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One buffer; payload words must skip offset and padding DWORDs
    task automatic buf_chk(input logic [1:0] al, input logic [4:0] of, input logic fs, ls,
        input logic [10:0] sz, pl, input logic er);
        int n0 = n_out;
        int b0 = n_bytes;
        int f0 = n_first;
        int l0 = n_last;
        host.send_buf(al, of, fs, ls, sz, pl);
        repeat (3) @(negedge ref_clk);
        chk("words", (sz + of + 3) / 4 - of[4:2], n_out - n0);
        chk("error", er, transmit_error_flag);
        chk("bytes", sz, n_bytes - b0);
        chk("first word", fs, n_first - f0);
        chk("last word", ls, n_last - l0);
    endtask
    task automatic t_align;
        for (int a = 0; a < 3; a++) begin
            buf_chk(2'(a), 5'h05, 1'b1, 1'b1, 11'h00A, 11'h00A, 1'b0);
            chk("align", a, end_align);
            chk("offset", 32'h5, start_offset);
            chk("size", 32'hA, buf_size);
        end
        buf_chk(2'h2, 5'h1F, 1'b1, 1'b1, 11'h7FF, 11'h7FF, 1'b0);
    endtask
    // Sum across fragments, then a short packet and a clear
    task automatic t_frag;
        buf_chk(2'h1, 5'h02, 1'b1, 1'b0, 11'h006, 11'h00E, 1'b0);
        chk("first", 32'h1, first_fragment_flag);
        buf_chk(2'h0, 5'h03, 1'b0, 1'b1, 11'h008, 11'h00E, 1'b0);
        buf_chk(2'h0, 5'h00, 1'b1, 1'b1, 11'h009, 11'h00A, 1'b1);
        error_clear = 1'b1;
        @(negedge ref_clk);
        error_clear = 1'b0;
        chk("cleared", 32'h0, transmit_error_flag);
    endtask
    task automatic t_rsvd;
        buf_chk(2'h3, 5'h00, 1'b1, 1'b1, 11'h004, 11'h004, 1'b1);
    endtask
    // Clock enable low freezes the flag even under a clear
    task automatic t_freeze;
        clk_en = 1'b0;
        error_clear = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("frozen", 32'h1, transmit_error_flag);
        clk_en = 1'b1;
        @(negedge ref_clk);
        error_clear = 1'b0;
        chk("thawed", 32'h0, transmit_error_flag);
    endtask
    initial begin
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
        t_align();
        t_frag();
        t_rsvd();
        t_freeze();
        results();
    end
    // Tests need about 600 cycles
    initial begin
        #20000;
        n_mismatch++;
        results();
    end
endmodule
`default_nettype wire
